// ==== rtl/icc_channel.sv ====
// Purpose: Input capture channel: timestamps pin edges from one of two time bases.
// Assumes: Pin and time bases synchronous to mclk_i; one access strobe per cycle.
// Notes:   Read data valid the cycle after the read strobe only.
// Contract
// - Each qualifying pin event stores the full 16-bit selected time base.
// - Time-base select set picks first time base, clear picks second.
// - Captures queue in a four-entry first-in first-out buffer.
// - Captures-per-interrupt field interrupts after every 1, 2, 3 or 4 captures.
// - Overrun flag is read-only, set by hardware, cleared only by hardware.
// - Buffer-not-empty flag reads 1 while unread captures remain.
// - Mode 000 turns channel off; mode 110 keeps it disabled.
// - Mode 001 captures both edges; interrupt on every capture.
// - Mode 010 captures falling edges, mode 011 rising edges.
// - Modes 100 and 101 capture every 4th and 16th rising edge.
// - Mode 111 is a rising-edge wake interrupt only in sleep or idle.
// - Halt-when-idle set stops the channel while the processor idles.
// - A pin edge can wake the device from sleep and idle.
// - Control bits 15-14 and 12-8 read as zero.
// - All control fields reset to zero.
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module icc_channel
    import icc_pkg::*;
#(
    parameter int DW    = 16,
    parameter int DEPTH = 4
) (
    input  wire logic          mclk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    input  wire logic          capture_input_pin_i,
    input  wire logic [DW-1:0] first_time_base_count_i,
    input  wire logic [DW-1:0] second_time_base_count_i,
    input  wire logic          cpu_idle_i,
    input  wire logic          cpu_sleep_i,
    input  wire logic [1:0]    addr_i,
    input  wire logic [15:0]   wdata_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output logic      [15:0]   rdata_o,
    output logic               capture_irq_o,
    output logic               wake_o,
    output logic               irq_o
);
    icc_bus_req_t bus;
    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    logic [15:0]   ctrl_reg;
    logic          pin_reg;
    logic [3:0]    pre_reg;
    logic [1:0]    cnt_reg;
    logic          ovf_reg;
    logic          cirq_reg;
    logic          wake_reg;
    logic [2:0]    evt_reg;
    logic [2:0]    mask_reg;
    logic [15:0]   rdata_reg;
    logic [DW-1:0] fifo_q;
    logic          fifo_full;
    logic          fifo_empty;
    logic [2:0]    fill_reg;

    // Decoded control fields
    wire icc_mode_t mode        = icc_mode_t'(ctrl_reg[ICC_BIT_MODE_LO +: 3]);
    wire [1:0]      cpi         = ctrl_reg[ICC_BIT_CPI_LO +: 2];
    wire            tsel        = ctrl_reg[ICC_BIT_TSEL];
    wire            halt_idle   = ctrl_reg[ICC_BIT_IDLE];

    wire wr_ctrl = bus.wr && (bus.addr == ICC_ADDR_CTRL);
    wire wr_mask = bus.wr && (bus.addr == ICC_ADDR_MASK);
    wire rd_buf  = bus.rd && (bus.addr == ICC_ADDR_BUF);
    wire rd_stat = bus.rd && (bus.addr == ICC_ADDR_STAT);

    wire rise = capture_input_pin_i && !pin_reg;
    wire fall = !capture_input_pin_i && pin_reg;

    wire is_off   = (mode == ICC_MODE_OFF);
    wire halted   = halt_idle && cpu_idle_i;
    wire cap_mode = !is_off && (mode != ICC_MODE_UNUSED) && (mode != ICC_MODE_WAKE);
    wire active   = cap_mode && !halted && !cpu_sleep_i;

    // Prescaler terminal count for divided modes
    wire [3:0] pre_last = (mode == ICC_MODE_RISE16) ? ICC_PRE16_LAST : ICC_PRE4_LAST;

    logic edge_hit;
    always_comb begin
        edge_hit = 1'b0;
        case (mode)
            ICC_MODE_BOTH:   edge_hit = rise || fall;
            ICC_MODE_FALL:   edge_hit = fall;
            ICC_MODE_RISE:   edge_hit = rise;
            ICC_MODE_RISE4,
            ICC_MODE_RISE16: edge_hit = rise && (pre_reg == pre_last);
            default:         edge_hit = 1'b0;
        endcase
    end

    wire capture  = active && edge_hit;
    wire accept   = capture && !fifo_full;
    wire overrun  = capture && fifo_full;
    wire [DW-1:0] snap = tsel ? first_time_base_count_i : second_time_base_count_i;

    // Mode 001 ignores the per-interrupt count
    wire [1:0] cpi_eff  = (mode == ICC_MODE_BOTH) ? 2'h0 : cpi;
    wire       cnt_done = (cnt_reg == cpi_eff);
    wire       cap_irq  = accept && cnt_done;

    // Wake on any edge in capture modes, rising only in mode 111
    wire low_power = cpu_sleep_i || cpu_idle_i;
    wire wake_evt  = low_power && ((mode == ICC_MODE_WAKE) ? rise : (cap_mode && (rise || fall)));

    wire       pop      = rd_buf && !fifo_empty;

    icc_fifo #(
        .WIDTH (DW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .flush_i (is_off),
        .push_i  (accept),
        .data_i  (snap),
        .pop_i   (pop),
        .data_o  (fifo_q),
        .full_o  (fifo_full),
        .empty_o (fifo_empty)
    );

    // Flags read clear as soon as the channel is off, before the flush lands
    wire [15:0] ctrl_view = (ctrl_reg & ICC_CTRL_WMASK)
                          | (16'(ovf_reg && !is_off) << ICC_BIT_OVF)
                          | (16'(!fifo_empty && !is_off) << ICC_BIT_BNE);

    wire [2:0] evt_in = {wake_evt, overrun, cap_irq};

    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        case (bus.addr)
            ICC_ADDR_CTRL: rd_mux = ctrl_view;
            ICC_ADDR_BUF:  rd_mux = 16'(fifo_q);
            ICC_ADDR_STAT: rd_mux = {13'h0000, evt_reg};
            ICC_ADDR_MASK: rd_mux = {13'h0000, mask_reg};
            default:       rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctrl_reg <= ICC_CTRL_RST;
            mask_reg <= ICC_EVT_RST;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                ctrl_reg <= bus.wdata & ICC_CTRL_WMASK;
            end
            if (wr_mask) begin
                mask_reg <= bus.wdata[2:0];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pin_reg  <= 1'b0;
            pre_reg  <= 4'h0;
            cnt_reg  <= 2'h0;
        end else if (ce_i) begin
            pin_reg <= capture_input_pin_i;
            if (is_off) begin
                pre_reg <= 4'h0;
                cnt_reg <= 2'h0;
            end else begin
                if (active && rise && (mode == ICC_MODE_RISE4 || mode == ICC_MODE_RISE16)) begin
                    pre_reg <= (pre_reg == pre_last) ? 4'h0 : pre_reg + 4'h1;
                end
                if (accept) begin
                    cnt_reg <= cnt_done ? 2'h0 : cnt_reg + 2'h1;
                end
            end
        end
    end

    // Local occupancy mirror, so the queue's internals are never reached into
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            fill_reg <= 3'h0;
        end else if (ce_i) begin
            if (is_off) begin
                fill_reg <= 3'h0;
            end else begin
                fill_reg <= fill_reg + 3'(accept) - 3'(pop);
            end
        end
    end

    // Overrun: set wins; cleared on last pop or channel off
    wire last_pop = pop && !accept && (fill_reg == 3'h1);
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ovf_reg <= 1'b0;
        end else if (ce_i) begin
            if (overrun) begin
                ovf_reg <= 1'b1;
            end else if (is_off || last_pop) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    // Status is cleared by reading it; a coincident event still lands
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            evt_reg   <= ICC_EVT_RST;
            rdata_reg <= 16'h0000;
            cirq_reg  <= 1'b0;
            wake_reg  <= 1'b0;
        end else if (ce_i) begin
            evt_reg   <= (rd_stat ? 3'h0 : evt_reg) | evt_in;
            rdata_reg <= bus.rd ? rd_mux : 16'h0000;
            cirq_reg  <= cap_irq;
            wake_reg  <= wake_evt;
        end
    end

    assign rdata_o       = rdata_reg;
    assign capture_irq_o = cirq_reg;
    assign wake_o        = wake_reg;
    assign irq_o         = |(evt_reg & mask_reg);
endmodule

// ==== rtl/icc_pkg.sv ====
// Purpose: Shared constants and types for the input capture channel.
// Assumes: One 25 MHz clock, plain register port with 16-bit data.
// Notes:   Offsets are word indices on the register port.
package icc_pkg;

    localparam logic [1:0]  ICC_ADDR_CTRL   = 2'h0;
    localparam logic [1:0]  ICC_ADDR_BUF    = 2'h1;
    localparam logic [1:0]  ICC_ADDR_STAT   = 2'h2;
    localparam logic [1:0]  ICC_ADDR_MASK   = 2'h3;

    localparam int          ICC_BIT_IDLE    = 13;
    localparam int          ICC_BIT_TSEL    = 7;
    localparam int          ICC_BIT_CPI_LO  = 5;
    localparam int          ICC_BIT_OVF     = 4;
    localparam int          ICC_BIT_BNE     = 3;
    localparam int          ICC_BIT_MODE_LO = 0;

    localparam logic [15:0] ICC_CTRL_RST    = 16'h0000;
    localparam logic [15:0] ICC_CTRL_WMASK  = 16'h20E7;
    localparam logic [2:0]  ICC_EVT_RST     = 3'h0;
    localparam logic [3:0]  ICC_PRE4_LAST   = 4'h3;
    localparam logic [3:0]  ICC_PRE16_LAST  = 4'hF;

    // Status/mask bit positions
    localparam int          ICC_EV_CAPIRQ   = 0;
    localparam int          ICC_EV_OVF      = 1;
    localparam int          ICC_EV_WAKE     = 2;

    typedef enum logic [2:0] {
        ICC_MODE_OFF   = 3'h0,
        ICC_MODE_BOTH  = 3'h1,
        ICC_MODE_FALL  = 3'h2,
        ICC_MODE_RISE  = 3'h3,
        ICC_MODE_RISE4 = 3'h4,
        ICC_MODE_RISE16= 3'h5,
        ICC_MODE_UNUSED= 3'h6,
        ICC_MODE_WAKE  = 3'h7
    } icc_mode_t;

    typedef struct packed {
        logic [1:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } icc_bus_req_t;

endpackage

// ==== rtl/icc_fifo.sv ====
// Purpose: Small capture queue, oldest entry first.
// Assumes: Push is refused by the caller when full.
// Notes:   Flush empties the queue in one cycle.
`timescale 1ns/1ps
module icc_fifo
    import icc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             flush_i,
    input  wire logic             push_i,
    input  wire logic [WIDTH-1:0] data_i,
    input  wire logic             pop_i,
    output logic      [WIDTH-1:0] data_o,
    output logic                  full_o,
    output logic                  empty_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic [AW:0]      cnt_reg;

    wire do_push = push_i && !full_o;
    wire do_pop  = pop_i && !empty_o;

    assign full_o  = (cnt_reg == (AW+1)'(DEPTH));
    assign empty_o = (cnt_reg == '0);
    assign data_o  = mem[rp_reg];

    always_ff @(posedge mclk_i) begin
        if (ce_i && do_push) begin
            mem[wp_reg] <= data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || (ce_i && flush_i)) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else if (ce_i) begin
            if (do_push) begin
                wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
            end
            if (do_pop) begin
                rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule

// ==== test/icc_channel_chk.sv ====
// Purpose: Port-level checks for the capture channel.
// Assumes: ce_i held high; pin synchronous to mclk_i.
// Notes:   Internal queue state is judged by the bench, not here.
`timescale 1ns/1ps
module icc_channel_chk
    import icc_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        capture_input_pin_i,
    input wire logic        cpu_idle_i,
    input wire logic        cpu_sleep_i,
    input wire logic [1:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        capture_irq_o,
    input wire logic        wake_o,
    input wire logic        irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence ctrl_rd; rd_i && addr_i == ICC_ADDR_CTRL; endsequence
    sequence ctrl_wr; wr_i && addr_i == ICC_ADDR_CTRL; endsequence
    // A pending edge could set flags in the same cycle, so only quiet pins count
    sequence pin_quiet;
        $stable(capture_input_pin_i) && $past(capture_input_pin_i) == $past(capture_input_pin_i, 2);
    endsequence
    sequence pin_moved;
        $past(capture_input_pin_i) != $past(capture_input_pin_i, 2) ||
        $past(capture_input_pin_i, 2) != $past(capture_input_pin_i, 3);
    endsequence
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    ctrl_rsvd_a: assert property (ctrl_rd |=> rdata_o[15:14] == 2'h0 && rdata_o[12:8] == 5'h00)
        else $error("reserved control bits not zero");
    ctrl_reset_a: assert property ($past(rst_i) && rd_i && addr_i == ICC_ADDR_CTRL |=> rdata_o == ICC_CTRL_RST)
        else $error("control not zero after reset");
    ctrl_keep_a: assert property (ctrl_wr ##1 ctrl_rd |=> (rdata_o & ICC_CTRL_WMASK) == ($past(wdata_i, 2) & ICC_CTRL_WMASK))
        else $error("control fields not kept");
    off_flags_a: assert property (ctrl_wr ##0 (wdata_i[2:0] == 3'h0) ##0 pin_quiet ##1 ctrl_rd |=> rdata_o[4:3] == 2'b00)
        else $error("flags survive channel off");
    wake_cause_a: assert property (wake_o |-> pin_moved)
        else $error("wake without pin edge");
    wake_state_a: assert property (wake_o |-> $past(cpu_idle_i) || $past(cpu_sleep_i) || $past(cpu_idle_i, 2) || $past(cpu_sleep_i, 2))
        else $error("wake while running");
    cirq_cause_a: assert property (capture_irq_o |-> pin_moved)
        else $error("capture interrupt without pin edge");
    stat_clear_a: assert property (rd_i && addr_i == ICC_ADDR_STAT ##0 pin_quiet |=> !irq_o)
        else $error("interrupt stays after status read");
endmodule

// ==== test/icc_pin_src.sv ====
// Purpose: External signal driving the capture pin.
// Assumes: Called just after a rising mclk_i edge.
// Notes:   Gap sets how slowly the signal moves.
`timescale 1ns/1ps
module icc_pin_src (
    input  wire logic mclk_i,
    output logic      pin_o
);
    initial pin_o = 1'b0;
    task automatic move(input logic lvl, input int gap);
        pin_o <= lvl;
        repeat (gap) @(posedge mclk_i);
    endtask
endmodule

// ==== test/test_input_capture_channel.sv ====
// Purpose: Self-checking bench for the capture channel.
// Assumes: Bus and pin change only right after rising edges.
// Notes:   Read data are matched in order against a queue of notes.
`timescale 1ns/1ps
module test_input_capture_channel;
    import icc_pkg::*;
    logic        mclk_i = 0, rst_i = 1, ce_i = 1, idle = 0, slp = 0;
    logic        wr_i = 0, rd_i = 0, rd_q = 0, pin, cirq, wake, irq_o, tsel, ovf;
    logic [1:0]  addr_i = 0, cpi;
    logic [15:0] wdata_i = 0, tb1 = 0, tb2 = 0, rdata_o;
    logic [15:0] exp_q[$], fq[$];
    int          n_fail = 0, comparisons = 0, cyc = 0, n_cirq = 0, n_wake = 0;
    int          m, pc, nc, ecirq;
    icc_pin_src pin_src_inst (.mclk_i(mclk_i), .pin_o(pin));
    icc_channel icc_channel_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
        .capture_input_pin_i(pin), .first_time_base_count_i(tb1),
        .second_time_base_count_i(tb2), .cpu_idle_i(idle), .cpu_sleep_i(slp),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .capture_irq_o(cirq), .wake_o(wake), .irq_o(irq_o));
    always #20 mclk_i = ~mclk_i;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic results;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        rd_q <= rd_i;
        if (cirq === 1'b1) n_cirq <= n_cirq + 1;
        if (wake === 1'b1) n_wake <= n_wake + 1;
        if (rd_q === 1'b1) chk("rdata", exp_q.pop_front(), rdata_o);
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end
    // Strobes are set every call so back-to-back accesses never assign twice
    task automatic acc(input logic w, input logic [1:0] a, input logic [15:0] d);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        if (!w) exp_q.push_back(d);
        @(posedge mclk_i);
    endtask
    task automatic quiet;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    function automatic logic [15:0] cw(input logic o, input logic b);
        return {8'h00, tsel, cpi, o, b, 3'(m)};
    endfunction
    task automatic edge_to(input logic lvl);
        logic [15:0] v, w;
        v = 16'($urandom);
        w = 16'($urandom);
        if (lvl) pc++;
        tb1 <= v;
        tb2 <= w;
        if (m == 1 || (m == 2 && !lvl) || (m == 3 && lvl) ||
            (lvl && ((m == 4 && pc % 4 == 0) || (m == 5 && pc % 16 == 0)))) begin
            if (fq.size() == 4) ovf = 1'b1;
            else begin
                fq.push_back(tsel ? v : w);
                nc++;
                if (m == 1 || nc == cpi + 1) begin
                    ecirq++;
                    nc = 0;
                end
            end
        end
        pin_src_inst.move(lvl, 3 + $urandom % 3);
    endtask
    initial begin
        void'($urandom(32'h4D7E));
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        acc(0, ICC_ADDR_CTRL, 16'h0000);
        acc(1, ICC_ADDR_CTRL, 16'hFFFF);
        acc(0, ICC_ADDR_CTRL, 16'h20E7);
        acc(1, ICC_ADDR_STAT, 16'hFFFF);
        acc(1, ICC_ADDR_MASK, 16'h0007);
        acc(0, ICC_ADDR_STAT, 16'h0000);
        acc(1, ICC_ADDR_CTRL, 16'h0000);
        acc(0, ICC_ADDR_CTRL, 16'h0000);
        for (int k = 1; k <= 5; k++) begin
            m = k;
            tsel = 1'($urandom);
            cpi = 2'($urandom);
            pc = 0;
            nc = 0;
            ecirq = 0;
            ovf = 1'b0;
            n_cirq = 0;
            acc(1, ICC_ADDR_CTRL, cw(1'b0, 1'b0));
            quiet();
            repeat (k == 5 ? 34 : 10) edge_to(!pin);
            chk("irq", 16'(ecirq != 0 || ovf), 16'(irq_o));
            chk("cirq", 16'(ecirq), 16'(n_cirq));
            acc(0, ICC_ADDR_CTRL, cw(ovf, fq.size() != 0));
            acc(0, ICC_ADDR_STAT, {14'h0000, ovf, ecirq != 0});
            quiet();
            chk("irq", 16'h0000, 16'(irq_o));
            if (k == 1) begin
                acc(1, ICC_ADDR_CTRL, 16'h0000);
                m = 0;
                tsel = 1'b0;
                cpi = 2'h0;
                fq.delete();
            end
            while (fq.size() > 0) acc(0, ICC_ADDR_BUF, fq.pop_front());
            acc(0, ICC_ADDR_CTRL, cw(1'b0, 1'b0));
            acc(1, ICC_ADDR_CTRL, 16'h0000);
            quiet();
        end
        m = 0;
        acc(1, ICC_ADDR_CTRL, 16'h2003);
        quiet();
        idle <= 1'b1;
        edge_to(1'b1);
        acc(0, ICC_ADDR_CTRL, 16'h2003);
        acc(1, ICC_ADDR_CTRL, 16'h0007);
        quiet();
        idle <= 1'b0;
        slp <= 1'b1;
        edge_to(1'b0);
        edge_to(1'b1);
        chk("wake", 16'h0002, 16'(n_wake));
        acc(0, ICC_ADDR_STAT, 16'h0004);
        quiet();
        repeat (2) @(posedge mclk_i);
        results();
    end
endmodule
bind icc_channel icc_channel_chk icc_channel_chk_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .capture_input_pin_i(capture_input_pin_i), .cpu_idle_i(cpu_idle_i),
    .cpu_sleep_i(cpu_sleep_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .capture_irq_o(capture_irq_o), .wake_o(wake_o),
    .irq_o(irq_o));
